/* shared/rx_event_pkg.sv */
// Purpose: Shared constants and carriers for the receive-port event status
// Assumes: One device clock; register engine gives byte-wide accesses
// Notes:   Addresses are the page-relative register byte addresses
package rx_event_pkg;

    localparam int NUM_PORTS = 2;
    localparam int NUM_GPIO  = 4;
    localparam int HI_W      = 5;
    localparam int LO_W      = 7;

    // Register addresses
    localparam logic [7:0] ADDR_PORT_SEL     = 8'h4C;
    localparam logic [7:0] ADDR_CAMERA_RX    = 8'h7A;
    localparam logic [7:0] ADDR_ICR_HI       = 8'hD8;
    localparam logic [7:0] ADDR_ICR_LO       = 8'hD9;
    localparam logic [7:0] ADDR_SUMMARY_HI   = 8'hDA;
    localparam logic [7:0] ADDR_SUMMARY_LO   = 8'hDB;
    localparam logic [7:0] ADDR_FWD_GPIO_STS = 8'hDC;
    localparam logic [7:0] ADDR_FWD_GPIO_ICR = 8'hDD;
    localparam logic [7:0] ADDR_SENSOR_RISE  = 8'hDE;
    localparam logic [7:0] ADDR_SENSOR_FALL  = 8'hDF;
    // Status registers that live outside this block; reads are snooped
    localparam logic [7:0] ADDR_RX_STATUS_1  = 8'h4D;
    localparam logic [7:0] ADDR_RX_STATUS_2  = 8'h4E;

    // Reset values
    localparam logic [7:0] PORT_SEL_RESET    = 8'h00;
    localparam logic [7:0] READ_ZERO         = 8'h00;

    // Port select: bit 0 picks the page seen by reads and writes
    localparam int PORT_SEL_BIT = 0;

    // High summary bit positions
    localparam int HI_CRC   = 0;
    localparam int HI_SEQ   = 1;
    localparam int HI_ENC   = 2;
    localparam int HI_SENS  = 3;
    localparam int HI_GPIO  = 4;
    localparam int ICR_HI_W = 3;

    // Low summary bit positions
    localparam int LO_LOCK  = 0;
    localparam int LO_VALID = 1;
    localparam int LO_PAR   = 2;
    localparam int LO_CAM   = 3;
    localparam int LO_OVF   = 4;
    localparam int LO_CNT   = 5;
    localparam int LO_LEN   = 6;

    // Forward GPIO status layout: flags above, live values below
    localparam int GPIO_FLAG_LSB = 4;
    localparam int GPIO_LIVE_LSB = 0;

    // Register access from the serial register engine
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_t;

    // Per-port event sources; levels and one-cycle pulses
    typedef struct packed {
        logic port_valid;       // Level
        logic locked;           // Level
        logic sensor_change;    // Pulse, already masked upstream
        logic enc_err;          // Pulse
        logic seq_err;          // Pulse
        logic crc_err;          // Pulse
        logic line_len_chg;     // Pulse
        logic line_cnt_chg;     // Pulse
        logic overflow;         // Pulse
        logic camera_err;       // Pulse
        logic parity_err;       // Pulse
    } port_events_t;

endpackage : rx_event_pkg

/* hw/sticky_flags.sv */
// Purpose: A row of sticky event flags with per-bit clear
// Assumes: set and clr are on the same clock as the flags
// Notes:   A set in the clearing cycle keeps the flag high
`timescale 1ns/1ps
`default_nettype none
module sticky_flags #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] q
);

    // Set wins over clear so an event in the read cycle is kept
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (ce) begin
            q <= set | (q & ~clr);
        end
    end

endmodule : sticky_flags
`default_nettype wire

/* hw/rx_port_event_status.sv */
// Purpose: Per-port event summary, forward GPIO status and enables
// Assumes: Event inputs come from logic on SYS_CLK; no resync needed
// Notes:   Read data is registered; read-clear acts on the read edge
//
// What this block does
// - GPIO change sets high bit 4; GPIO-status read clears
// - Sensor change sets high bit 3; sensor reads clear
// - Encoding error sets high bit 2; status-two read clears
// - Sequence error sets high bit 1; status-one read clears
// - CRC error sets high bit 0; status-one read clears
// - Line length change sets low bit 6
// - Line count change sets low bit 5
// - Buffer overflow sets low bit 4
// - Camera receiver error sets low bit 3
// - Parity error sets low bit 2
// - Port valid change sets low bit 1
// - Lock change sets low bit 0
// - GPIO event flags in bits 7:4, read-clear
// - Live GPIO values in bits 3:0, no side effects
// - Status held per port, paged by port select
// - Interrupt only when matching enable bit set, except GPIO and sensor bits, which always raise it
// - Separate rise and fall enables qualify GPIO events
`timescale 1ns/1ps
`default_nettype none
module rx_port_event_status (
    input  wire logic                                  SYS_CLK,
    input  wire logic                                  RST,
    input  wire logic                                  CE,
    input  wire rx_event_pkg::reg_req_t                REG_REQ,
    output logic [7:0]                                 REG_RDATA,
    input  wire rx_event_pkg::port_events_t [1:0]      EV,
    input  wire logic [1:0][rx_event_pkg::NUM_GPIO-1:0] GPIO,
    output logic [1:0]                                 PORT_IRQ
);

    localparam int NP = rx_event_pkg::NUM_PORTS;
    localparam int NG = rx_event_pkg::NUM_GPIO;
    localparam int HW = rx_event_pkg::HI_W;
    localparam int LW = rx_event_pkg::LO_W;
    localparam int IW = rx_event_pkg::ICR_HI_W;

    logic [7:0]    port_sel;
    logic          page;
    logic [HW-1:0] hi_q        [NP];
    logic [LW-1:0] lo_q        [NP];
    logic [NG-1:0] gpio_flag   [NP];
    logic [IW-1:0] icr_hi      [NP];
    logic [LW-1:0] icr_lo      [NP];
    logic [2*NG-1:0] gpio_icr  [NP];
    logic [NG-1:0] gpio_prev   [NP];
    logic          valid_prev  [NP];
    logic          lock_prev   [NP];
    logic [7:0]    rd_mux;

    // Address decode of the incoming access
    wire rd_any  = REG_REQ.rd && CE;
    wire wr_any  = REG_REQ.wr && CE;
    wire a_sts1  = REG_REQ.addr == rx_event_pkg::ADDR_RX_STATUS_1;
    wire a_sts2  = REG_REQ.addr == rx_event_pkg::ADDR_RX_STATUS_2;
    wire a_cam   = REG_REQ.addr == rx_event_pkg::ADDR_CAMERA_RX;
    wire a_sens  = (REG_REQ.addr == rx_event_pkg::ADDR_SENSOR_RISE) ||
                   (REG_REQ.addr == rx_event_pkg::ADDR_SENSOR_FALL);
    wire a_gsts  = REG_REQ.addr == rx_event_pkg::ADDR_FWD_GPIO_STS;
    wire a_psel  = REG_REQ.addr == rx_event_pkg::ADDR_PORT_SEL;
    wire a_ichi  = REG_REQ.addr == rx_event_pkg::ADDR_ICR_HI;
    wire a_iclo  = REG_REQ.addr == rx_event_pkg::ADDR_ICR_LO;
    wire a_gicr  = REG_REQ.addr == rx_event_pkg::ADDR_FWD_GPIO_ICR;

    assign page = port_sel[rx_event_pkg::PORT_SEL_BIT];

    // Port select page register; shared by both ports
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            port_sel <= rx_event_pkg::PORT_SEL_RESET;
        end else if (wr_any && a_psel) begin
            port_sel <= REG_REQ.wdata;
        end
    end

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_port
            logic [HW-1:0] hi_set;
            logic [HW-1:0] hi_clr;
            logic [LW-1:0] lo_set;
            logic [LW-1:0] lo_clr;
            logic [NG-1:0] rise;
            logic [NG-1:0] fall;
            logic [NG-1:0] gpio_ev;

            // Accesses reach only the paged port's copy
            wire sel     = page == 1'(p);
            wire rd_sts1 = rd_any && sel && a_sts1;
            wire rd_sts2 = rd_any && sel && a_sts2;
            wire rd_cam  = rd_any && sel && a_cam;
            wire rd_sens = rd_any && sel && a_sens;
            wire rd_gsts = rd_any && sel && a_gsts;
            wire wr_sel  = wr_any && sel;

            // GPIO edges, each direction gated by its own enable
            assign rise = GPIO[p] & ~gpio_prev[p];
            assign fall = ~GPIO[p] & gpio_prev[p];
            for (genvar g = 0; g < NG; g++) begin : g_gpio
                assign gpio_ev[g] = (rise[g] && gpio_icr[p][2*g]) ||
                                    (fall[g] && gpio_icr[p][2*g+1]);
            end

            // High summary sources and clearing reads
            assign hi_set[rx_event_pkg::HI_GPIO] = |gpio_ev;
            assign hi_clr[rx_event_pkg::HI_GPIO] = rd_gsts;
            assign hi_set[rx_event_pkg::HI_SENS] = EV[p].sensor_change;
            assign hi_clr[rx_event_pkg::HI_SENS] = rd_sens;
            assign hi_set[rx_event_pkg::HI_ENC]  = EV[p].enc_err;
            assign hi_clr[rx_event_pkg::HI_ENC]  = rd_sts2;
            assign hi_set[rx_event_pkg::HI_SEQ]  = EV[p].seq_err;
            assign hi_clr[rx_event_pkg::HI_SEQ]  = rd_sts1;
            assign hi_set[rx_event_pkg::HI_CRC]  = EV[p].crc_err;
            assign hi_clr[rx_event_pkg::HI_CRC]  = rd_sts1;

            // Low summary sources and clearing reads
            assign lo_set[rx_event_pkg::LO_LEN]   = EV[p].line_len_chg;
            assign lo_clr[rx_event_pkg::LO_LEN]   = rd_sts2;
            assign lo_set[rx_event_pkg::LO_CNT]   = EV[p].line_cnt_chg;
            assign lo_clr[rx_event_pkg::LO_CNT]   = rd_sts2;
            assign lo_set[rx_event_pkg::LO_OVF]   = EV[p].overflow;
            assign lo_clr[rx_event_pkg::LO_OVF]   = rd_sts2;
            assign lo_set[rx_event_pkg::LO_CAM]   = EV[p].camera_err;
            assign lo_clr[rx_event_pkg::LO_CAM]   = rd_cam;
            assign lo_set[rx_event_pkg::LO_PAR]   = EV[p].parity_err;
            assign lo_clr[rx_event_pkg::LO_PAR]   = rd_sts1;
            assign lo_set[rx_event_pkg::LO_VALID] =
                EV[p].port_valid ^ valid_prev[p];
            assign lo_clr[rx_event_pkg::LO_VALID] = rd_sts1;
            assign lo_set[rx_event_pkg::LO_LOCK]  =
                EV[p].locked ^ lock_prev[p];
            assign lo_clr[rx_event_pkg::LO_LOCK]  = rd_sts1;

            // Sticky rows; set beats the clearing read
            sticky_flags #(.W(HW)) u_hi (
                .clk (SYS_CLK),
                .rst (RST),
                .ce  (CE),
                .set (hi_set),
                .clr (hi_clr),
                .q   (hi_q[p])
            );
            sticky_flags #(.W(LW)) u_lo (
                .clk (SYS_CLK),
                .rst (RST),
                .ce  (CE),
                .set (lo_set),
                .clr (lo_clr),
                .q   (lo_q[p])
            );
            sticky_flags #(.W(NG)) u_gpio (
                .clk (SYS_CLK),
                .rst (RST),
                .ce  (CE),
                .set (gpio_ev),
                .clr ({NG{rd_gsts}}),
                .q   (gpio_flag[p])
            );

            // Previous levels for change and edge detection
            always_ff @(posedge SYS_CLK or posedge RST) begin
                if (RST) begin
                    gpio_prev[p]  <= '0;
                    valid_prev[p] <= 1'b0;
                    lock_prev[p]  <= 1'b0;
                end else if (CE) begin
                    gpio_prev[p]  <= GPIO[p];
                    valid_prev[p] <= EV[p].port_valid;
                    lock_prev[p]  <= EV[p].locked;
                end
            end

            // Per-port enable registers, written through the page
            always_ff @(posedge SYS_CLK or posedge RST) begin
                if (RST) begin
                    icr_hi[p]   <= '0;
                    icr_lo[p]   <= '0;
                    gpio_icr[p] <= '0;
                end else if (wr_sel) begin
                    if (a_ichi) icr_hi[p]   <= REG_REQ.wdata[IW-1:0];
                    if (a_iclo) icr_lo[p]   <= REG_REQ.wdata[LW-1:0];
                    if (a_gicr) gpio_icr[p] <= REG_REQ.wdata;
                end
            end

            // Status always records; only enabled bits raise the line.
            // GPIO and sensor bits are already qualified upstream.
            assign PORT_IRQ[p] = |(hi_q[p][IW-1:0] & icr_hi[p]) ||
                                 |(lo_q[p] & icr_lo[p]) ||
                                 hi_q[p][rx_event_pkg::HI_GPIO] ||
                                 hi_q[p][rx_event_pkg::HI_SENS];
        end
    endgenerate

    // Read mux over the paged port; unmapped addresses read zero
    wire [7:0] rd_hi   = {{(8-HW){1'b0}}, hi_q[page]};
    wire [7:0] rd_lo   = {{(8-LW){1'b0}}, lo_q[page]};
    wire [7:0] rd_fwd  = {gpio_flag[page], GPIO[page]};
    wire [7:0] rd_ichi = {{(8-IW){1'b0}}, icr_hi[page]};
    wire [7:0] rd_iclo = {{(8-LW){1'b0}}, icr_lo[page]};

    always_comb begin
        case (REG_REQ.addr)
            rx_event_pkg::ADDR_PORT_SEL:     rd_mux = port_sel;
            rx_event_pkg::ADDR_ICR_HI:       rd_mux = rd_ichi;
            rx_event_pkg::ADDR_ICR_LO:       rd_mux = rd_iclo;
            rx_event_pkg::ADDR_SUMMARY_HI:   rd_mux = rd_hi;
            rx_event_pkg::ADDR_SUMMARY_LO:   rd_mux = rd_lo;
            rx_event_pkg::ADDR_FWD_GPIO_STS: rd_mux = rd_fwd;
            rx_event_pkg::ADDR_FWD_GPIO_ICR: rd_mux = gpio_icr[page];
            default:                         rd_mux = rx_event_pkg::READ_ZERO;
        endcase
    end

    // Data captured on the read edge, before the clear takes effect
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            REG_RDATA <= rx_event_pkg::READ_ZERO;
        end else if (rd_any) begin
            REG_RDATA <= rd_mux;
        end
    end

    // Checks on port 0 and on the read data register
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    wire p0     = page == 1'b0;
    wire rd0    = rd_any && p0;

    a_crc_sets_hi: assert property (
        CE && EV[0].crc_err |=> hi_q[0][rx_event_pkg::HI_CRC] [*1]
    ) else $error("CRC error did not set summary bit");

    a_sts1_clears_seq: assert property (
        rd0 && a_sts1 && !EV[0].seq_err
        |=> !hi_q[0][rx_event_pkg::HI_SEQ]
    ) else $error("Status one read left sequence flag set");

    a_sts2_clears_enc: assert property (
        rd0 && a_sts2 && !EV[0].enc_err
        |=> !hi_q[0][rx_event_pkg::HI_ENC]
    ) else $error("Status two read left encoding flag set");

    a_cam_read_clears: assert property (
        rd0 && a_cam && !EV[0].camera_err
        |=> !lo_q[0][rx_event_pkg::LO_CAM]
    ) else $error("Camera status read left flag set");

    a_lock_change_flag: assert property (
        CE && !$past(RST) &&
        (EV[0].locked != $past(EV[0].locked)) && $past(CE)
        ##1 1 |-> lo_q[0][rx_event_pkg::LO_LOCK]
    ) else $error("Lock change not recorded");

    a_gpio_rise_flag: assert property (
        CE && GPIO[0][0] && !gpio_prev[0][0] && gpio_icr[0][0]
        |=> gpio_flag[0][0] && hi_q[0][rx_event_pkg::HI_GPIO]
    ) else $error("Enabled GPIO rise not flagged");

    a_gpio_read_clears: assert property (
        rd0 && a_gsts && (GPIO[0] == gpio_prev[0])
        |=> gpio_flag[0] == '0 && !hi_q[0][rx_event_pkg::HI_GPIO]
    ) else $error("GPIO status read did not clear flags");

    a_gpio_live_read: assert property (
        rd0 && a_gsts |=> REG_RDATA[NG-1:0] == $past(GPIO[0])
    ) else $error("Live GPIO value wrong in read data");

    a_set_beats_clear: assert property (
        rd0 && a_sts2 && EV[0].overflow
        |=> lo_q[0][rx_event_pkg::LO_OVF]
    ) else $error("Event lost in clearing read cycle");

    a_irq_needs_enable: assert property (
        icr_hi[0] == '0 && icr_lo[0] == '0 &&
        hi_q[0][rx_event_pkg::HI_GPIO] == 1'b0 &&
        hi_q[0][rx_event_pkg::HI_SENS] == 1'b0 |-> !PORT_IRQ[0]
    ) else $error("Interrupt raised with enables clear");

    // History is cleared by reset, so the edge just after it is skipped
    a_valid_change_flag: assert property (
        CE && $past(CE) && !$past(RST) &&
        (EV[0].port_valid != $past(EV[0].port_valid))
        |=> lo_q[0][rx_event_pkg::LO_VALID]
    ) else $error("Port valid change not recorded");

    a_sens_read_clears: assert property (
        rd0 && a_sens && !EV[0].sensor_change
        |=> !hi_q[0][rx_event_pkg::HI_SENS]
    ) else $error("Sensor status read left flag set");

    a_len_sets_lo: assert property (
        CE && EV[0].line_len_chg |=> lo_q[0][rx_event_pkg::LO_LEN]
    ) else $error("Line length change did not set summary bit");

    // A low pin cannot rise, and its fall is masked here
    a_fall_needs_enable: assert property (
        CE && !GPIO[0][0] && !gpio_icr[0][1] && !gpio_flag[0][0]
        |=> !gpio_flag[0][0]
    ) else $error("Disabled GPIO fall set a flag");

    // Frozen clock enable must hold the read data register
    a_ce_holds_rdata: assert property (
        !CE |=> $stable(REG_RDATA)
    ) else $error("Read data moved while clock enable low");

endmodule : rx_port_event_status
`default_nettype wire

/* tb/host_model.sv */
// Purpose: Register-engine host issuing single-byte accesses to the block
// Assumes: Requests launch on a falling edge and last one cycle
// Notes:   Released address and data are inverted, so stale values never
//          look valid to the design
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic                   clk,
    input  wire logic [7:0]             rdata,
    output var  rx_event_pkg::reg_req_t req
);
    // Idle bus at time zero
    initial req = '0;

    // One access: held across the rising edge that takes it, read data
    // picked up one cycle later because the design registers it
    task automatic access(input logic [7:0] a, input logic w,
                          input logic [7:0] wd, output logic [7:0] d);
        @(negedge clk);
        req = '{addr: a, wr: w, rd: !w, wdata: wd};
        @(negedge clk);
        d = rdata;
        req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~wd};
    endtask : access

    task automatic wr(input logic [7:0] a, input logic [7:0] wd);
        logic [7:0] d;
        access(a, 1'b1, wd, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        access(a, 1'b0, 8'h00, d);
    endtask : rd

    // Page choice must precede any port-specific access
    task automatic sel(input logic [7:0] p);
        wr(rx_event_pkg::ADDR_PORT_SEL, p);
    endtask : sel
endmodule : host_model
`default_nettype wire

/* tb/rx_port_event_status_tb_top.sv */
// Purpose: Self-checking bench for the receive-port event status block
// Assumes: Inputs change on the falling edge; host_model drives requests
// Notes:   Table rows cover the summary events except GPIO; hand tests cover the rest
`timescale 1ns/1ps
`default_nettype none
module rx_port_event_status_tb_top;
    typedef struct {
        string      name;
        int         b;
        logic [7:0] addr;
        logic [7:0] mask;
        logic [7:0] clr;
        bit         lvl;
    } row_t;

    logic                                  sys_clk;
    logic                                  rst;
    logic                                  ce;
    rx_event_pkg::reg_req_t                req;
    logic [7:0]                            rdata;
    rx_event_pkg::port_events_t [1:0]      ev;
    logic [1:0][rx_event_pkg::NUM_GPIO-1:0] gpio;
    logic [1:0]                            irq;
    logic [7:0]                            d;
    int                                    num_errors;
    int                                    tests_run;
    row_t rows [12] = '{
        '{"crc", 5, 8'hDA, 8'h01, 8'h4D, 0}, '{"seq", 6, 8'hDA, 8'h02, 8'h4D, 0},
        '{"enc", 7, 8'hDA, 8'h04, 8'h4E, 0}, '{"sen_r", 8, 8'hDA, 8'h08, 8'hDE, 0},
        '{"sen_f", 8, 8'hDA, 8'h08, 8'hDF, 0}, '{"len", 4, 8'hDB, 8'h40, 8'h4E, 0},
        '{"cnt", 3, 8'hDB, 8'h20, 8'h4E, 0}, '{"ovf", 2, 8'hDB, 8'h10, 8'h4E, 0},
        '{"cam", 1, 8'hDB, 8'h08, 8'h7A, 0}, '{"par", 0, 8'hDB, 8'h04, 8'h4D, 0},
        '{"lock", 9, 8'hDB, 8'h01, 8'h4D, 1}, '{"valid", 10, 8'hDB, 8'h02, 8'h4D, 1}};

    rx_port_event_status dut (.SYS_CLK(sys_clk), .RST(rst), .CE(ce),
        .REG_REQ(req), .REG_RDATA(rdata), .EV(ev), .GPIO(gpio),
        .PORT_IRQ(irq));
    host_model host (.clk(sys_clk), .rdata(rdata), .req(req));

    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic final_report();
        if (num_errors == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // Pulse events last one cycle; level events toggle and stay
    task automatic hit(input int p, input int b, input bit lvl);
        @(negedge sys_clk);
        ev[p][b] = lvl ? ~ev[p][b] : 1'b1;
        if (!lvl) begin
            @(negedge sys_clk);
            ev[p][b] = 1'b0;
        end
    endtask : hit

    // Bound on a hang; the whole sequence needs well under 2000 cycles
    initial begin
        #(4000 * 20);
        num_errors++;
        final_report();
    end

    initial begin
        rst = 1'b1;
        ce = 1'b1;
        ev = '0;
        gpio = '0;
        num_errors = 0;
        tests_run = 0;
        repeat (8) @(negedge sys_clk);
        rst = 1'b0;
        foreach (rows[i]) begin
            if (i < 3) begin
                host.rd(rows[i].addr - 8'h01 + 8'h01 + i[7:0], d);
            end
        end
        host.rd(8'hDA, d);
        chk("sum_hi_rst", 8'h00, d);
        host.rd(8'hDB, d);
        chk("sum_lo_rst", 8'h00, d);
        host.rd(8'hDC, d);
        chk("gpio_rst", 8'h00, d);
        host.wr(8'hD8, 8'h07);
        host.wr(8'hD9, 8'h7F);
        host.rd(8'hD8, d);
        chk("icr_hi", 8'h07, d);
        host.rd(8'hD9, d);
        chk("icr_lo", 8'h7F, d);
        host.rd(8'h00, d);
        chk("unmapped", 8'h00, d);
        // Set, survive a foreign status read, stay on its own page, clear
        foreach (rows[i]) begin
            hit(0, rows[i].b, rows[i].lvl);
            host.rd(rows[i].addr, d);
            chk(rows[i].name, rows[i].mask, d);
            chk("irq0", 8'h01, {7'h00, irq[0]});
            host.rd((rows[i].clr == 8'h4E) ? 8'h4D : 8'h4E, d);
            host.rd(rows[i].addr, d);
            chk(rows[i].name, rows[i].mask, d);
            host.sel(8'h01);
            host.rd(rows[i].addr, d);
            chk("other_page", 8'h00, d);
            host.sel(8'h00);
            host.rd(rows[i].clr, d);
            host.rd(rows[i].addr, d);
            chk(rows[i].name, 8'h00, d);
            chk("irq0", 8'h00, {7'h00, irq[0]});
        end
        // GPIO0 rise and GPIO1 fall enabled only
        host.wr(8'hDD, 8'h09);
        host.rd(8'hDD, d);
        chk("gpio_icr", 8'h09, d);
        @(negedge sys_clk) gpio[0] = 4'b0001;
        host.rd(8'hDA, d);
        chk("sum_gpio", 8'h10, d);
        host.rd(8'hDC, d);
        chk("gpio_sts", 8'h11, d);
        host.rd(8'hDC, d);
        chk("gpio_sts", 8'h01, d);
        host.rd(8'hDA, d);
        chk("sum_gpio", 8'h00, d);
        @(negedge sys_clk) gpio[0] = 4'b0011;
        host.rd(8'hDC, d);
        chk("gpio_rise_off", 8'h03, d);
        @(negedge sys_clk) gpio[0] = 4'b0010;
        host.rd(8'hDC, d);
        chk("gpio_fall_off", 8'h02, d);
        @(negedge sys_clk) gpio[0] = 4'b0000;
        host.rd(8'hDC, d);
        chk("gpio_fall_on", 8'h20, d);
        // Event in the very cycle of the clearing read must survive
        fork
            host.rd(8'h4D, d);
            hit(0, 5, 0);
        join
        host.rd(8'hDA, d);
        chk("set_wins", 8'h01, d);
        host.rd(8'h4D, d);
        fork
            host.rd(8'h4E, d);
            hit(0, 2, 0);
        join
        host.rd(8'hDB, d);
        chk("set_wins_lo", 8'h10, d);
        host.rd(8'h4E, d);
        // Port 1 has no enables: status only, no request
        host.sel(8'h01);
        hit(1, 5, 0);
        host.rd(8'hDA, d);
        chk("port1_crc", 8'h01, d);
        chk("irq1", 8'h00, {7'h00, irq[1]});
        host.sel(8'h00);
        host.rd(8'hDA, d);
        chk("port0_crc", 8'h00, d);
        // Frozen block ignores events
        @(negedge sys_clk) ce = 1'b0;
        hit(0, 6, 0);
        @(negedge sys_clk) ce = 1'b1;
        host.rd(8'hDA, d);
        chk("ce_off", 8'h00, d);
        // Mid-run reset clears flags, enables and the page select
        host.sel(8'h01);
        host.rd(8'h4C, d);
        chk("sel_rb", 8'h01, d);
        hit(0, 5, 0);
        @(negedge sys_clk) rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        host.rd(8'h4C, d);
        chk("sel_rst", 8'h00, d);
        host.rd(8'hDA, d);
        chk("hi_rst", 8'h00, d);
        host.rd(8'hD9, d);
        chk("icr_rst", 8'h00, d);
        // Levels still high against cleared history: one change each
        host.rd(8'hDB, d);
        chk("lo_rst", 8'h03, d);
        chk("irq_rst", 8'h00, {6'h00, irq});
        host.sel(8'h01);
        host.rd(8'hDA, d);
        chk("hi1_rst", 8'h00, d);
        final_report();
    end
endmodule : rx_port_event_status_tb_top
`default_nettype wire
